// file: hdl/ahp_pkg.sv
// ---------------------------------------------------------------------------
// Package for the host power and reset supervisor.
// ---------------------------------------------------------------------------
// Holds register offsets, field positions, reset values and timing counts.
// Assumes a 20 MHz core clock and an APB register master.
//
// Summary of operation
// - Pins float idle, driven only during pulse.
// - Auto bit picks active level for both pins.
// - Invert bits make reset/power pulses drive high when the auto bit is clear.
// - Confirm held 4 s, host up: 1 s reset.
// - After key reset, ignore commands until restart.
// - Confirm 0.25 s, host down: power pulse, restart.
// - Cancel 4 s: power pulse, extend up to 5 s.
// - Blank display while host sense low, if enabled.
// - Stay active; sense rise restarts like power-up.
// - Config command: mask, pulse length, sense selector.
// - Selector 0 pin sense, 1 supply sense default.
// - Watchdog timeout zero disables the watchdog.
// - Expiry: one reset pulse, watchdog then inactive.
// - Watchdog starts disabled after power-up.
// - Readback: mask, counter, selector, zero reserved.
// - Readback also returns contrast and backlight bytes.
// - Store command saves mask, pulse length and selector as boot.
// ---------------------------------------------------------------------------
package ahp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_NS       = 31250000;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam logic [8:0]  HOLD_LONG_T   = 9'h080;
    localparam logic [8:0]  HOLD_SHORT_T  = 9'h008;
    localparam logic [8:0]  ONE_SEC_T     = 9'h020;
    localparam logic [8:0]  EXTEND_T      = 9'h0A0;
    localparam logic [7:0]  ADDR_CFG      = 8'h00;
    localparam logic [7:0]  ADDR_WDOG     = 8'h04;
    localparam logic [7:0]  ADDR_STORE    = 8'h08;
    localparam logic [7:0]  ADDR_DISP     = 8'h0C;
    localparam logic [7:0]  ADDR_RB_IDX   = 8'h10;
    localparam logic [7:0]  ADDR_RB_DATA  = 8'h14;
    localparam logic [7:0]  ADDR_STATUS   = 8'h18;
    localparam int unsigned BIT_AUTO      = 0;
    localparam int unsigned BIT_RST_INV   = 1;
    localparam int unsigned BIT_PWR_INV   = 2;
    localparam int unsigned BIT_BLANK     = 4;
    localparam int unsigned BIT_KEY_RST   = 5;
    localparam int unsigned BIT_KEY_PON   = 6;
    localparam int unsigned BIT_KEY_POFF  = 7;
    localparam logic [7:0]  RST_MASK      = 8'h00;
    localparam logic [7:0]  RST_PLEN      = 8'h20;
    localparam logic        RST_SENSE     = 1'b1;
    localparam logic [31:0] RST_DISP      = 32'h64641064;
    localparam logic [3:0]  RB_LAST       = 4'hE;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_KEY_RST = 3'b001,
        ST_PWR_ON  = 3'b010,
        ST_PWR_OFF = 3'b011,
        ST_WD_RST  = 3'b100,
        ST_RESTART = 3'b101
    } ahp_state_t;
endpackage

// file: hdl/ahp_supervisor.sv
// ---------------------------------------------------------------------------
// Host power and reset supervisor with APB register access.
// ---------------------------------------------------------------------------
// Assumes external pull resistors on the two switch pins and raw keys.
`timescale 1ns/1ps
module ahp_supervisor import ahp_pkg::*; #(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        key_confirm_i,
    input  wire logic        key_cancel_i,
    input  wire logic        sense_pin_i,
    input  wire logic        sense_supply_i,
    input  wire logic        rst_pin_i,
    input  wire logic        pwr_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe_n_o,
    output logic             pwr_pin_o,
    output logic             pwr_pin_oe_n_o,
    output logic             blank_when_host_down_o,
    output logic [1:0]       msg_o,
    output logic             restart_o
);
    if (TICK_LEN < 2 || TICK_LEN > 32'h000FFFFF) begin : g_bad_tick
        $error("TICK_LEN must be from 2 to the tick counter range");
    end

    // -----------------------------------------------------------------------
    // Input synchronisers.
    // -----------------------------------------------------------------------
    logic [5:0] raw_in;
    logic [5:0] s1_ff;
    logic [5:0] s2_ff;
    logic [5:0] s3_ff;
    logic [5:0] in_ff;
    assign raw_in = {pwr_pin_i, rst_pin_i, sense_supply_i, sense_pin_i,
                     key_cancel_i, key_confirm_i};
    for (genvar g = 0; g < 6; g++) begin : g_sync
        always_ff @(posedge core_clk_i) begin
            s1_ff[g] <= raw_in[g];
            s2_ff[g] <= s1_ff[g];
            s3_ff[g] <= s2_ff[g];
            // The filter follows the pin in reset, so release shows no edge.
            if (!rst_n_i) begin
                in_ff[g] <= s3_ff[g];
            end else if (s2_ff[g] == s3_ff[g]) begin
                in_ff[g] <= s3_ff[g];
            end
        end
    end

    // -----------------------------------------------------------------------
    // Registers and state.
    // -----------------------------------------------------------------------
    ahp_state_t  state_ff;
    logic [7:0]  mask_ff;
    logic [7:0]  plen_ff;
    logic        ssel_ff;
    logic [7:0]  boot_mask_ff;
    logic [7:0]  boot_plen_ff;
    logic        boot_ssel_ff;
    logic [31:0] disp_ff;
    logic [3:0]  rb_idx_ff;
    logic [7:0]  wd_cnt_ff;
    logic        wd_en_ff;
    logic        wd_pend_ff;
    logic [4:0]  sec_div_ff;
    logic [19:0] tick_cnt_ff;
    logic        tick;
    logic [8:0]  hold_ok_ff;
    logic [8:0]  hold_cn_ff;
    logic [8:0]  pulse_cnt_ff;
    logic        sense_q_ff;
    logic        rst_idle_ff;
    logic        pwr_idle_ff;
    logic        sense;
    logic        busy;
    logic [8:0]  plen_t;
    logic        wr_en;
    logic        sec_tick;
    logic        wd_fire;

    assign sense  = ssel_ff ? in_ff[3] : in_ff[2];
    assign busy   = (state_ff == ST_KEY_RST) || (state_ff == ST_RESTART);
    assign wr_en  = psel_i && penable_i && pwrite_i && !busy;
    assign plen_t = (plen_ff == 8'h00) ? ONE_SEC_T : {1'b0, plen_ff};
    assign tick   = (tick_cnt_ff == 20'(TICK_LEN - 1));
    assign sec_tick = tick && (sec_div_ff == 5'h1F);
    // A feed or a restart in the expiry cycle wins over the expiry.
    assign wd_fire  = wd_en_ff && sec_tick && (wd_cnt_ff == 8'h01) &&
                      !(wr_en && paddr_i == ADDR_WDOG) &&
                      (state_ff != ST_RESTART);

    function automatic logic act_level(input logic auto_on,
                                       input logic inv,
                                       input logic idle_lvl);
        act_level = auto_on ? !idle_lvl : inv;
    endfunction

    // -----------------------------------------------------------------------
    // Tick divider, 1/32 second.
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || tick) begin
            tick_cnt_ff <= 20'h00000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 20'h00001;
        end
    end

    // Hold counters run only while the key stays down.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !in_ff[0]) begin
            hold_ok_ff <= 9'h000;
        end else if (tick && hold_ok_ff != 9'h1FF) begin
            hold_ok_ff <= hold_ok_ff + 9'h001;
        end
        if (!rst_n_i || !in_ff[1]) begin
            hold_cn_ff <= 9'h000;
        end else if (tick && hold_cn_ff != 9'h1FF) begin
            hold_cn_ff <= hold_cn_ff + 9'h001;
        end
    end

    // -----------------------------------------------------------------------
    // Configuration, boot copy and display settings.
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mask_ff      <= RST_MASK;
            plen_ff      <= RST_PLEN;
            ssel_ff      <= RST_SENSE;
            boot_mask_ff <= RST_MASK;
            boot_plen_ff <= RST_PLEN;
            boot_ssel_ff <= RST_SENSE;
            disp_ff      <= RST_DISP;
            rb_idx_ff    <= 4'h0;
        end else if (state_ff == ST_RESTART) begin
            mask_ff <= boot_mask_ff;
            plen_ff <= boot_plen_ff;
            ssel_ff <= boot_ssel_ff;
        end else if (wr_en) begin
            if (paddr_i == ADDR_CFG && pwdata_i[25:24] != 2'b00) begin
                mask_ff <= pwdata_i[7:0];
                if (pwdata_i[25:24] >= 2'd2) begin
                    plen_ff <= pwdata_i[15:8];
                end
                if (pwdata_i[25:24] == 2'd3) begin
                    ssel_ff <= pwdata_i[16];
                end
            end
            if (paddr_i == ADDR_STORE && pwdata_i[0]) begin
                boot_mask_ff <= mask_ff;
                boot_plen_ff <= plen_ff;
                boot_ssel_ff <= ssel_ff;
            end
            if (paddr_i == ADDR_DISP) begin
                disp_ff <= pwdata_i;
            end
            if (paddr_i == ADDR_RB_IDX) begin
                rb_idx_ff <= pwdata_i[3:0];
            end
        end
    end

    // -----------------------------------------------------------------------
    // Host watchdog, counted in whole seconds.
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || state_ff == ST_RESTART) begin
            wd_en_ff   <= 1'b0;
            wd_cnt_ff  <= 8'h00;
            sec_div_ff <= 5'h00;
        end else if (wr_en && paddr_i == ADDR_WDOG) begin
            wd_cnt_ff  <= pwdata_i[7:0];
            wd_en_ff   <= (pwdata_i[7:0] != 8'h00);
            sec_div_ff <= 5'h00;
        end else if (wd_en_ff && tick) begin
            sec_div_ff <= sec_div_ff + 5'h01;
            if (sec_tick) begin
                wd_cnt_ff <= wd_cnt_ff - 8'h01;
                if (wd_cnt_ff == 8'h01) begin
                    wd_en_ff <= 1'b0;
                end
            end
        end
    end

    // The expiry waits here through a power-off pulse; a restart clears it.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || state_ff == ST_RESTART) begin
            wd_pend_ff <= 1'b0;
        end else if (wd_fire) begin
            wd_pend_ff <= 1'b1;
        end else if (state_ff == ST_WD_RST) begin
            wd_pend_ff <= 1'b0;
        end
    end

    // -----------------------------------------------------------------------
    // Sequencer.
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_ff     <= ST_IDLE;
            pulse_cnt_ff <= 9'h000;
            sense_q_ff   <= sense;
        end else begin
            sense_q_ff <= sense;
            if (tick) begin
                pulse_cnt_ff <= pulse_cnt_ff + 9'h001;
            end
            case (state_ff)
                ST_IDLE: begin
                    pulse_cnt_ff <= 9'h000;
                    if (wd_pend_ff) begin
                        state_ff <= ST_WD_RST;
                    end else if (mask_ff[BIT_KEY_RST] && sense &&
                                 hold_ok_ff >= HOLD_LONG_T) begin
                        state_ff <= ST_KEY_RST;
                    end else if (mask_ff[BIT_KEY_POFF] && sense &&
                                 hold_cn_ff >= HOLD_LONG_T) begin
                        state_ff <= ST_PWR_OFF;
                    end else if (mask_ff[BIT_KEY_PON] && !sense &&
                                 hold_ok_ff >= HOLD_SHORT_T) begin
                        state_ff <= ST_PWR_ON;
                    end else if (sense && !sense_q_ff) begin
                        state_ff <= ST_RESTART;
                    end
                end
                ST_KEY_RST: begin
                    if (pulse_cnt_ff >= ONE_SEC_T) begin
                        state_ff <= ST_RESTART;
                    end
                end
                ST_PWR_ON: begin
                    if (pulse_cnt_ff >= plen_t) begin
                        state_ff <= ST_RESTART;
                    end
                end
                ST_PWR_OFF: begin
                    if (pulse_cnt_ff >= plen_t && (!in_ff[1] ||
                        pulse_cnt_ff >= plen_t + EXTEND_T)) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_WD_RST: begin
                    if (pulse_cnt_ff >= ONE_SEC_T) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_RESTART: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Pin drivers; the idle level is learnt only while the pin floats.
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rst_idle_ff    <= 1'b1;
            pwr_idle_ff    <= 1'b1;
            rst_pin_o      <= 1'b0;
            rst_pin_oe_n_o <= 1'b1;
            pwr_pin_o      <= 1'b0;
            pwr_pin_oe_n_o <= 1'b1;
        end else begin
            if (rst_pin_oe_n_o) begin
                rst_idle_ff <= in_ff[4];
            end
            if (pwr_pin_oe_n_o) begin
                pwr_idle_ff <= in_ff[5];
            end
            rst_pin_oe_n_o <= !(state_ff == ST_KEY_RST ||
                                state_ff == ST_WD_RST);
            pwr_pin_oe_n_o <= !(state_ff == ST_PWR_ON ||
                                state_ff == ST_PWR_OFF);
            rst_pin_o <= act_level(mask_ff[BIT_AUTO],
                                   mask_ff[BIT_RST_INV], rst_idle_ff);
            pwr_pin_o <= act_level(mask_ff[BIT_AUTO],
                                   mask_ff[BIT_PWR_INV], pwr_idle_ff);
        end
    end

    // -----------------------------------------------------------------------
    // Display side outputs.
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            blank_when_host_down_o <= 1'b0;
            msg_o                  <= 2'b00;
            restart_o              <= 1'b0;
        end else begin
            blank_when_host_down_o <= mask_ff[BIT_BLANK] && !sense;
            restart_o <= (state_ff == ST_RESTART);
            case (state_ff)
                ST_KEY_RST: msg_o <= 2'b01;
                ST_PWR_ON:  msg_o <= 2'b10;
                ST_PWR_OFF: msg_o <= 2'b11;
                default:    msg_o <= 2'b00;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // APB read path, captured in the setup cycle.
    // -----------------------------------------------------------------------
    logic [7:0] rb_byte;
    always_comb begin
        case (rb_idx_ff)
            4'h7:    rb_byte = mask_ff;
            4'h8:    rb_byte = wd_cnt_ff;
            4'h9:    rb_byte = disp_ff[7:0];
            4'hA:    rb_byte = disp_ff[15:8];
            4'hB:    rb_byte = {7'h00, ssel_ff};
            4'hD:    rb_byte = disp_ff[23:16];
            4'hE:    rb_byte = disp_ff[31:24];
            default: rb_byte = 8'h00;
        endcase
    end

    assign pready_o = 1'b1;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            pslverr_o <= (paddr_i > ADDR_STATUS) || (paddr_i[1:0] != 2'b00);
            case (paddr_i)
                ADDR_CFG:     prdata_o <= {15'h0000, ssel_ff, plen_ff, mask_ff};
                ADDR_WDOG:    prdata_o <= {24'h000000, wd_cnt_ff};
                ADDR_DISP:    prdata_o <= disp_ff;
                ADDR_RB_IDX:  prdata_o <= {28'h0000000, rb_idx_ff};
                ADDR_RB_DATA: prdata_o <= {24'h000000, rb_byte};
                ADDR_STATUS:  prdata_o <= {21'h000000, msg_o, state_ff,
                                           !pwr_pin_oe_n_o, !rst_pin_oe_n_o,
                                           busy, blank_when_host_down_o,
                                           sense};
                default:      prdata_o <= 32'h00000000;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------------
    AST_RST_FLOAT_IDLE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) state_ff == ST_IDLE |=> rst_pin_oe_n_o)
        else $error("Reset pin driven while idle.");
    AST_AUTO_LEVEL: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !rst_pin_oe_n_o && $stable(mask_ff) &&
        mask_ff[BIT_AUTO] |-> rst_pin_o == !rst_idle_ff)
        else $error("Auto level not inverse of idle level.");
    AST_PWR_INVERT: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !pwr_pin_oe_n_o && $stable(mask_ff) &&
        !mask_ff[BIT_AUTO] |-> pwr_pin_o == mask_ff[BIT_PWR_INV])
        else $error("Power pin level ignores invert bit.");
    AST_KEY_RST_START: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) state_ff == ST_IDLE && !wd_pend_ff &&
        mask_ff[BIT_KEY_RST] && sense && hold_ok_ff >= HOLD_LONG_T
        |=> state_ff == ST_KEY_RST ##1 !rst_pin_oe_n_o)
        else $error("Key reset did not start.");
    AST_BUSY_IGNORE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) busy && state_ff != ST_RESTART
        |=> $stable(mask_ff) && $stable(plen_ff) && $stable(disp_ff) &&
        $stable(rb_idx_ff))
        else $error("Command taken while busy.");
    AST_BLANK: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) mask_ff[BIT_BLANK] && !sense &&
        $stable(sense) && $stable(mask_ff)
        |=> blank_when_host_down_o)
        else $error("Display not blanked with host down.");
    AST_WD_ZERO_OFF: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wr_en && paddr_i == ADDR_WDOG &&
        pwdata_i[7:0] == 8'h00 |=> !wd_en_ff)
        else $error("Zero timeout left watchdog running.");
    AST_WD_FIRE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wd_fire
        |=> !wd_en_ff && wd_cnt_ff == 8'h00 && wd_pend_ff)
        else $error("Watchdog expiry not handled.");
    AST_WD_RESTART: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) state_ff == ST_RESTART |=> !wd_en_ff)
        else $error("Watchdog survived restart.");
    AST_PULSE_LEN: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) state_ff == ST_PWR_ON &&
        pulse_cnt_ff >= plen_t |=> state_ff == ST_RESTART)
        else $error("Power-on pulse did not end in restart.");
endmodule // ahp_supervisor

// file: verif/ahp_host_model.sv
// Host board model: switch inputs with pull-ups and a host-alive sense.
// Assumes the supervisor drives each pin only while its enable is low.
`timescale 1ns/1ps
module ahp_host_model (
    input  wire logic host_on_i,
    input  wire logic rst_pin_i,
    input  wire logic rst_oe_n_i,
    input  wire logic pwr_pin_i,
    input  wire logic pwr_oe_n_i,
    output logic      rst_wire_o,
    output logic      pwr_wire_o,
    output logic      sense_pin_o,
    output logic      sense_supply_o
);
    // Host leaves the switch pins floating with pull-ups.
    // Released pins float up, so the learnt active level is low.
    assign rst_wire_o     = rst_oe_n_i ? 1'b1 : rst_pin_i;
    assign pwr_wire_o     = pwr_oe_n_i ? 1'b1 : pwr_pin_i;
    // Both sense paths follow the host supply.
    assign sense_pin_o    = host_on_i;
    assign sense_supply_o = host_on_i;
endmodule // ahp_host_model

// file: verif/test_ahp_supervisor.sv
// Bench for the host power and reset supervisor over APB.
// Assumes the host model resolves the switch pins and the host sense.
`timescale 1ns/1ps
module test_ahp_supervisor import ahp_pkg::*; ;
    localparam int TL = 4;
    logic        clk = 1'b0, rst_n = 1'b0, host_on = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, k_ok = 1'b0, k_x = 1'b0;
    logic        s_pin, s_sup, r_w, p_w, r_o, r_oe_n, p_o, p_oe_n;
    logic        blank, rstart;
    logic [1:0]  msg;
    logic [7:0]  rb [15] = '{0, 0, 0, 0, 0, 0, 0, 8'h10, 0, 8'h11,
                             8'h22, 1, 0, 8'h33, 8'h44};
    logic [7:0]  masks [3] = '{8'h00, 8'h02, 8'h03};
    int          mismatches = 0, samples_checked = 0, cyc = 0, n;

    ahp_supervisor #(.TICK_LEN(TL)) ahp_supervisor_i (.core_clk_i(clk),
        .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .key_confirm_i(k_ok), .key_cancel_i(k_x), .sense_pin_i(s_pin),
        .sense_supply_i(s_sup), .rst_pin_i(r_w), .pwr_pin_i(p_w),
        .rst_pin_o(r_o), .rst_pin_oe_n_o(r_oe_n), .pwr_pin_o(p_o),
        .pwr_pin_oe_n_o(p_oe_n), .blank_when_host_down_o(blank),
        .msg_o(msg), .restart_o(rstart));
    ahp_host_model ahp_host_model_i (.host_on_i(host_on),
        .rst_pin_i(r_o), .rst_oe_n_i(r_oe_n), .pwr_pin_i(p_o),
        .pwr_oe_n_i(p_oe_n), .rst_wire_o(r_w), .pwr_wire_o(p_w),
        .sense_pin_o(s_pin), .sense_supply_o(s_sup));

    always #25 clk = ~clk;
    // A hang is cut short here; it counts as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for a pin pulse, checks its level, then measures its width.
    task automatic pulse(input bit pw, input int lim, input logic lvl,
                         input bit cm, input logic [1:0] m);
        n = 0;
        while ((pw ? p_oe_n : r_oe_n) !== 1'b0 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(32'(pw ? p_o : r_o), 32'(lvl));
        if (cm) chk(32'(msg), 32'(m));
        n = 0;
        while ((pw ? p_oe_n : r_oe_n) === 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic wait_restart();
        n = 0;
        while (rstart !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(32'(rstart), 32'h1);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_WDOG, 32'h0);
        chk(rd, 32'h0);
        chk(32'(r_oe_n & p_oe_n), 32'h1);
        apb(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h00012000);
        apb(1'b1, ADDR_CFG, 32'h01000010);
        apb(1'b1, ADDR_DISP, 32'h44332211);
        for (int i = 0; i < 15; i++) begin
            apb(1'b1, ADDR_RB_IDX, 32'(i));
            apb(1'b0, ADDR_RB_DATA, 32'h0);
            chk(rd, 32'(rb[i]));
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk(32'(pslverr), 32'h1);
        apb(1'b1, ADDR_CFG, 32'h03002010);
        apb(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h00002010);
        $display("test readback done");
        apb(1'b1, ADDR_WDOG, 32'h1);
        repeat (100) @(negedge clk);
        apb(1'b1, ADDR_WDOG, 32'h1);
        repeat (100) @(negedge clk);
        chk(32'(r_oe_n), 32'h1);
        apb(1'b1, ADDR_WDOG, 32'h0);
        repeat (200) @(negedge clk);
        chk(32'(r_oe_n), 32'h1);
        foreach (masks[i]) begin
            apb(1'b1, ADDR_CFG, {24'h010000, masks[i]});
            apb(1'b1, ADDR_WDOG, 32'h1);
            pulse(1'b0, 300, masks[i] == 8'h02, 1'b0, 2'd0);
            chk(32'(n >= 31 * TL && n <= 33 * TL), 32'h1);
            repeat (200) @(negedge clk);
            chk(32'(r_oe_n), 32'h1);
        end
        $display("test watchdog done");
        apb(1'b1, ADDR_CFG, 32'h01000010);
        host_on <= 1'b0;
        repeat (20) @(negedge clk);
        chk(32'(blank), 32'h1);
        apb(1'b1, ADDR_CFG, 32'h02000444);
        @(posedge clk) k_ok <= 1'b1;
        pulse(1'b1, 200, 1'b1, 1'b1, 2'd2);
        chk(32'(n >= 3 * TL && n <= 5 * TL), 32'h1);
        wait_restart();
        @(posedge clk) k_ok <= 1'b0;
        apb(1'b1, ADDR_CFG, 32'h01000030);
        apb(1'b1, ADDR_STORE, 32'h1);
        @(posedge clk) host_on <= 1'b1;
        wait_restart();
        apb(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h00012030);
        $display("test power on and store done");
        apb(1'b1, ADDR_CFG, 32'h020008B0);
        @(posedge clk) k_x <= 1'b1;
        pulse(1'b1, 900, 1'b0, 1'b1, 2'd3);
        chk(32'(n >= 167 * TL && n <= 169 * TL), 32'h1);
        @(posedge clk) k_x <= 1'b0;
        repeat (100) @(negedge clk);
        chk(32'(p_oe_n), 32'h1);
        $display("test power off done");
        @(posedge clk) k_ok <= 1'b1;
        pulse(1'b0, 900, 1'b0, 1'b1, 2'd1);
        chk(32'(n >= 31 * TL && n <= 33 * TL), 32'h1);
        wait_restart();
        @(posedge clk) k_ok <= 1'b0;
        $display("test key reset done");
        finish_test();
    end
endmodule // test_ahp_supervisor
